// [logic/fcp_config_pins.sv]
// Purpose: configuration pin logic: mode straps, init handshake, data loading
// Assumes: all pin inputs are asynchronous to clk; all but scan_select pass two flip-flops
// Notes: master modes derive cfg_clock from the internal oscillator divider
//
`include "fcp_map.svh"

// Overview of operation
// - mode select straps latched at init_n rising edge choose the configuration mode.
// - oscillator speed strap latched at init_n rise; low 10 MHz, high 1.25 MHz.
// - cfg_busy_high is driven high until configuration completes, then user pin.
// - cfg_busy_low is driven low until configuration completes, then user pin.
// - init_n is pulled low during power stabilisation and memory clearing.
// - an external low on init_n holds the device in its wait state.
// - async peripheral mode selects the device when chip_sel_low low, chip_sel_high high.
// - a write strobe low while selected loads the data byte into the buffer.
// - read strobe low while selected drives bit 7 as ready status.
// - host avoids simultaneous strobes; if both low, write wins and read ignored.
// - slave parallel mode qualifies bytes with write strobe and both chip selects.
// - master parallel mode drives an 18-bit ROM address.
// - parallel and peripheral modes take bytes on the data bus with pull-ups.
// - chain serial output changes only on falling cfg_clock edges.
// - without boundary scan, scan functions are disabled once configuration completes.
// - configuration pins have pull-ups during configuration, become user pins after.
// - serial modes take one bit per cfg_clock on cfg_serial_in.
// - peripheral mode asserts byte_ready when another byte may be written.
module fcp_config_pins #(
    parameter int CFG_BYTES = `FCP_CFG_BYTES,
    parameter int AW = $clog2(CFG_BYTES)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] config_mode_select,
    input wire logic osc_speed_select,
    input wire logic init_n_in,
    output logic init_n_out,
    output logic init_n_oe,
    input wire logic chip_sel_low,
    input wire logic chip_sel_high,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic [7:0] cfg_data_in,
    output logic cfg_d7_out,
    output logic cfg_d7_oe,
    input wire logic cfg_clock_in,
    output logic cfg_clock_out,
    output logic cfg_clock_oe,
    input wire logic cfg_serial_in,
    output logic chain_serial_out,
    output logic [`FCP_ROM_AW-1:0] rom_address,
    output logic byte_ready,
    output logic cfg_busy_high,
    output logic cfg_busy_low,
    output logic cfg_pins_oe,
    output logic cfg_pullup_en,
    input wire logic scan_select,
    output logic scan_disable,
    output logic cfg_done,
    input wire logic [AW-1:0] cfg_mem_raddr,
    output logic [7:0] cfg_mem_rdata
);
    localparam int NPIN = $bits(fcp_pkg::fcp_pins_t);

    fcp_pkg::fcp_pins_t pins_in;
    fcp_pkg::fcp_pins_t p;
    logic [NPIN-1:0] meta_r;
    logic [NPIN-1:0] sync_r;

    assign pins_in = '{init_n: init_n_in, cs_low_n: chip_sel_low, cs_high: chip_sel_high,
                       wr_n: write_strobe_n, rd_n: read_strobe_n, cfg_clock: cfg_clock_in,
                       ser: cfg_serial_in, data: cfg_data_in,
                       mode_sel: config_mode_select, osc_sel: osc_speed_select};

    // two flops per pin; the first stage feeds only the second
    for (genvar i = 0; i < NPIN; i++) begin : g_sync
        always_ff @(posedge clk) begin
            if (rst) begin
                meta_r[i] <= 1'b1;
                sync_r[i] <= 1'b1;
            end else begin
                meta_r[i] <= pins_in[i];
                sync_r[i] <= meta_r[i];
            end
        end
    end
    assign p = sync_r;

    fcp_pkg::fcp_state_t state_r, state_nxt;
    fcp_pkg::fcp_mode_t mode_r, mode_nxt, mode_dec;
    logic osc_slow_r, osc_slow_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [2:0] osc_cnt_r, osc_cnt_nxt;
    logic cfg_clock_o_r, cfg_clock_o_nxt;
    logic [`FCP_ROM_AW-1:0] addr_r, addr_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [2:0] bitn_r, bitn_nxt;
    logic [AW-1:0] wptr_r, wptr_nxt;
    logic [3:0] busy_r, busy_nxt;
    logic d7oe_r, d7oe_nxt;
    logic d7_r, d7_nxt;
    logic dout_r, dout_nxt;
    logic init_prev_r, wr_prev_r, cfg_clock_prev_r;
    logic mem_we, acc, sel, is_master, osc_tick, cfg_clock_rise, cfg_clock_fall, init_rise;
    logic [AW-1:0] mem_waddr;
    logic [7:0] mem_wdata, acc_byte;
    logic [2:0] osc_div_m1;

    always_comb begin
        case (p.mode_sel)
            `FCP_MSEL_SPAR: mode_dec = fcp_pkg::FCP_SPAR;
            `FCP_MSEL_MPAR: mode_dec = fcp_pkg::FCP_MPAR;
            `FCP_MSEL_APER: mode_dec = fcp_pkg::FCP_APER;
            `FCP_MSEL_SPER: mode_dec = fcp_pkg::FCP_SPER;
            `FCP_MSEL_SSER: mode_dec = fcp_pkg::FCP_SSER;
            default: mode_dec = fcp_pkg::FCP_MSER;
        endcase
    end

    always_comb begin
        sel = ~p.cs_low_n & p.cs_high;
        is_master = (mode_r == fcp_pkg::FCP_MSER) || (mode_r == fcp_pkg::FCP_MPAR)
                    || (mode_r == fcp_pkg::FCP_APER);
        osc_div_m1 = osc_slow_r ? 3'(`FCP_OSC_DIV_SLOW - 1) : 3'(`FCP_OSC_DIV_FAST - 1);
        osc_tick = (osc_cnt_r == osc_div_m1);
        init_rise = p.init_n & ~init_prev_r;
        // slave modes follow the outside cfg_clock edges
        if (is_master) begin
            cfg_clock_rise = (state_r == fcp_pkg::FCP_ST_LOAD) & osc_tick & ~cfg_clock_o_r;
            // forcing the clock low on completion is a fall as well
            cfg_clock_fall = cfg_clock_o_r & ((state_r == fcp_pkg::FCP_ST_DONE)
                        | ((state_r == fcp_pkg::FCP_ST_LOAD) & osc_tick));
        end else begin
            cfg_clock_rise = p.cfg_clock & ~cfg_clock_prev_r;
            cfg_clock_fall = ~p.cfg_clock & cfg_clock_prev_r;
        end
    end

    always_comb begin
        state_nxt = state_r;
        mode_nxt = mode_r;
        osc_slow_nxt = osc_slow_r;
        cnt_nxt = cnt_r;
        osc_cnt_nxt = osc_tick ? 3'h0 : osc_cnt_r + 3'h1;
        cfg_clock_o_nxt = cfg_clock_o_r;
        addr_nxt = addr_r;
        shift_nxt = shift_r;
        bitn_nxt = bitn_r;
        wptr_nxt = wptr_r;
        busy_nxt = busy_r;
        dout_nxt = dout_r;
        mem_we = 1'b0;
        mem_waddr = wptr_r;
        mem_wdata = 8'h00;
        acc = 1'b0;
        acc_byte = p.data;
        case (state_r)
            fcp_pkg::FCP_ST_POWER: begin
                cnt_nxt = cnt_r + 16'h0001;
                if (cnt_r == 16'(`FCP_PWR_STAB_CYC - 1)) begin
                    cnt_nxt = 16'h0000;
                    state_nxt = fcp_pkg::FCP_ST_CLEAR;
                end
            end
            fcp_pkg::FCP_ST_CLEAR: begin
                mem_we = 1'b1;
                mem_waddr = AW'(cnt_r);
                cnt_nxt = cnt_r + 16'h0001;
                if (cnt_r == 16'(CFG_BYTES - 1)) begin
                    state_nxt = fcp_pkg::FCP_ST_WAIT;
                end
            end
            fcp_pkg::FCP_ST_WAIT: begin
                if (init_rise) begin
                    mode_nxt = mode_dec;
                    osc_slow_nxt = p.osc_sel;
                    state_nxt = fcp_pkg::FCP_ST_LOAD;
                end
            end
            fcp_pkg::FCP_ST_LOAD: begin
                if (is_master && osc_tick) begin
                    cfg_clock_o_nxt = ~cfg_clock_o_r;
                end
                // chain output moves on falling edges only
                if (cfg_clock_fall) begin
                    dout_nxt = shift_r[0];
                end
                case (mode_r)
                    fcp_pkg::FCP_MSER, fcp_pkg::FCP_SSER: begin
                        // one serial bit per rising edge
                        if (cfg_clock_rise) begin
                            shift_nxt = {shift_r[6:0], p.ser};
                            bitn_nxt = bitn_r + 3'h1;
                            acc = (bitn_r == 3'h7);
                            acc_byte = {shift_r[6:0], p.ser};
                        end
                    end
                    fcp_pkg::FCP_MPAR: begin
                        if (cfg_clock_rise) begin
                            acc = 1'b1;
                            addr_nxt = addr_r + 18'h00001;
                        end
                    end
                    fcp_pkg::FCP_APER: begin
                        if (cfg_clock_rise && busy_r != 4'h0) begin
                            busy_nxt = busy_r - 4'h1;
                        end
                        // write strobe loads the byte buffer
                        if (sel && wr_prev_r && !p.wr_n && busy_r == 4'h0) begin
                            acc = 1'b1;
                            busy_nxt = 4'(`FCP_BYTE_BITS);
                        end
                    end
                    default: begin
                        if (cfg_clock_rise && sel && !p.wr_n) begin
                            acc = 1'b1;
                        end
                    end
                endcase
                // bytes from the data bus or the serial shifter are stored
                if (acc) begin
                    mem_we = 1'b1;
                    mem_wdata = acc_byte;
                    wptr_nxt = wptr_r + AW'(1);
                    if (mode_r != fcp_pkg::FCP_MSER && mode_r != fcp_pkg::FCP_SSER) begin
                        shift_nxt = acc_byte;
                    end
                    if (wptr_r == AW'(CFG_BYTES - 1)) begin
                        state_nxt = fcp_pkg::FCP_ST_DONE;
                    end
                end
            end
            fcp_pkg::FCP_ST_DONE: begin
                cfg_clock_o_nxt = 1'b0;
                // last stored bit still reaches the chain
                if (cfg_clock_fall) begin
                    dout_nxt = shift_r[0];
                end
            end
            default: state_nxt = fcp_pkg::FCP_ST_POWER;
        endcase
    end

    always_comb begin
        // bit 7 reports ready while reading
        // a low write strobe suppresses the read
        // drive drops when read ends or select drops
        d7oe_nxt = (state_r == fcp_pkg::FCP_ST_LOAD) && (mode_r == fcp_pkg::FCP_APER)
                   && sel && !p.rd_n && p.wr_n;
        d7_nxt = (busy_r == 4'h0);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= fcp_pkg::FCP_ST_POWER;
            mode_r <= fcp_pkg::FCP_MSER;
            osc_slow_r <= 1'b0;
            cnt_r <= 16'h0000;
            osc_cnt_r <= 3'h0;
            cfg_clock_o_r <= 1'b0;
            addr_r <= 18'h00000;
            shift_r <= 8'h00;
            bitn_r <= 3'h0;
            wptr_r <= '0;
            busy_r <= 4'h0;
            d7oe_r <= 1'b0;
            d7_r <= 1'b0;
            dout_r <= 1'b0;
            init_prev_r <= 1'b1;
            wr_prev_r <= 1'b1;
            cfg_clock_prev_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            mode_r <= mode_nxt;
            osc_slow_r <= osc_slow_nxt;
            cnt_r <= cnt_nxt;
            osc_cnt_r <= osc_cnt_nxt;
            cfg_clock_o_r <= cfg_clock_o_nxt;
            addr_r <= addr_nxt;
            shift_r <= shift_nxt;
            bitn_r <= bitn_nxt;
            wptr_r <= wptr_nxt;
            busy_r <= busy_nxt;
            d7oe_r <= d7oe_nxt;
            d7_r <= d7_nxt;
            dout_r <= dout_nxt;
            init_prev_r <= p.init_n;
            wr_prev_r <= p.wr_n;
            cfg_clock_prev_r <= p.cfg_clock;
        end
    end

    fcp_cfg_mem #(.DW(8), .DEPTH(CFG_BYTES), .AW(AW)) u_mem (
        .clk(clk),
        .rst(rst),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(cfg_mem_raddr),
        .rdata(cfg_mem_rdata)
    );

    // open-drain low while powering and clearing
    assign init_n_out = 1'b0;
    assign init_n_oe = (state_r == fcp_pkg::FCP_ST_POWER) || (state_r == fcp_pkg::FCP_ST_CLEAR);
    assign cfg_done = (state_r == fcp_pkg::FCP_ST_DONE);
    assign cfg_busy_high = ~cfg_done;
    assign cfg_busy_low = cfg_done;
    // pull-ups and pin ownership until done
    assign cfg_pins_oe = ~cfg_done;
    assign cfg_pullup_en = ~cfg_done;
    assign scan_disable = cfg_done & ~scan_select;
    assign byte_ready = (state_r == fcp_pkg::FCP_ST_LOAD) && (busy_r == 4'h0);
    assign cfg_d7_out = d7_r;
    assign cfg_d7_oe = d7oe_r;
    assign cfg_clock_out = cfg_clock_o_r;
    assign cfg_clock_oe = is_master && (state_r == fcp_pkg::FCP_ST_LOAD);
    assign chain_serial_out = dout_r;
    assign rom_address = addr_r;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    property p_init_low;
        (state_r == fcp_pkg::FCP_ST_CLEAR) |-> init_n_oe && !init_n_out;
    endproperty
    a_init_low: assert property (p_init_low) else $error("init not held low");
    property p_wait_hold;
        (state_r == fcp_pkg::FCP_ST_WAIT) && !p.init_n |=> (state_r == fcp_pkg::FCP_ST_WAIT);
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("left wait early");
    property p_mode_latch;
        (state_r == fcp_pkg::FCP_ST_WAIT) && init_rise |=> mode_r == $past(mode_dec);
    endproperty
    a_mode_latch: assert property (p_mode_latch) else $error("mode not latched");
    property p_osc_latch;
        (state_r == fcp_pkg::FCP_ST_WAIT) && init_rise |=> osc_slow_r == $past(p.osc_sel);
    endproperty
    a_osc_latch: assert property (p_osc_latch) else $error("osc speed not latched");
    property p_busy_high;
        !cfg_done |-> cfg_busy_high && cfg_pins_oe;
    endproperty
    a_busy_high: assert property (p_busy_high) else $error("busy high wrong");
    property p_busy_low;
        (state_r != fcp_pkg::FCP_ST_DONE) |-> !cfg_busy_low;
    endproperty
    a_busy_low: assert property (p_busy_low) else $error("busy low wrong");
    property p_wr_wins;
        !p.wr_n |=> !cfg_d7_oe;
    endproperty
    a_wr_wins: assert property (p_wr_wins) else $error("read served during write");
    property p_d7_release;
        p.rd_n || !sel |=> !cfg_d7_oe;
    endproperty
    a_d7_release: assert property (p_d7_release) else $error("bit 7 still driven");
    property p_dout_fall;
        !$stable(chain_serial_out) |-> $past(cfg_clock_fall);
    endproperty
    a_dout_fall: assert property (p_dout_fall) else $error("chain out moved off edge");
    property p_rom_step;
        acc && (mode_r == fcp_pkg::FCP_MPAR) |=> rom_address == $past(rom_address) + 18'h00001;
    endproperty
    a_rom_step: assert property (p_rom_step) else $error("rom address did not step");
    property p_scan_off;
        cfg_done && !scan_select |-> scan_disable && !cfg_pullup_en;
    endproperty
    a_scan_off: assert property (p_scan_off) else $error("scan not disabled");
    property p_aper_busy;
        acc && (mode_r == fcp_pkg::FCP_APER) |=> !byte_ready [*2];
    endproperty
    a_aper_busy: assert property (p_aper_busy) else $error("ready right after write");

    c_done: cover property (state_r == fcp_pkg::FCP_ST_LOAD ##1 cfg_done);
    c_aper_write: cover property (acc && mode_r == fcp_pkg::FCP_APER);
    c_d7_read: cover property (cfg_d7_oe && cfg_d7_out);
    c_serial_byte: cover property (acc && mode_r == fcp_pkg::FCP_SSER);
endmodule // fcp_config_pins

// [logic/fcp_map.svh]
// Purpose: constants for the configuration pin interface
// Assumes: 10 MHz system clock
// Notes: counts are derived from times and rates
`ifndef FCP_MAP_SVH
`define FCP_MAP_SVH

`define FCP_CLK_KHZ 10000
`define FCP_OSC_FAST_KHZ 10000
`define FCP_OSC_SLOW_KHZ 1250
`define FCP_OSC_DIV_FAST (`FCP_CLK_KHZ / `FCP_OSC_FAST_KHZ)
`define FCP_OSC_DIV_SLOW (`FCP_CLK_KHZ / `FCP_OSC_SLOW_KHZ)
`define FCP_PWR_STAB_US 10
`define FCP_PWR_STAB_CYC ((`FCP_PWR_STAB_US * `FCP_CLK_KHZ + 999) / 1000)
`define FCP_CFG_BYTES 64
`define FCP_BYTE_BITS 8
`define FCP_ROM_AW 18
// mode select codes
`define FCP_MSEL_MSER 3'h0
`define FCP_MSEL_SPAR 3'h1
`define FCP_MSEL_MPAR 3'h2
`define FCP_MSEL_APER 3'h3
`define FCP_MSEL_SPER 3'h4
`define FCP_MSEL_SSER 3'h7

`endif

// [logic/fcp_pkg.sv]
// Purpose: types for the configuration pin interface
// Assumes: nothing
// Notes: pin struct carries the synchronised pin inputs
package fcp_pkg;
    typedef enum logic [2:0] {
        FCP_MSER, FCP_SSER, FCP_MPAR, FCP_SPAR, FCP_APER, FCP_SPER
    } fcp_mode_t;

    typedef enum logic [2:0] {
        FCP_ST_POWER, FCP_ST_CLEAR, FCP_ST_WAIT, FCP_ST_LOAD, FCP_ST_DONE
    } fcp_state_t;

    typedef struct packed {
        logic init_n;
        logic cs_low_n;
        logic cs_high;
        logic wr_n;
        logic rd_n;
        logic cfg_clock;
        logic ser;
        logic [7:0] data;
        logic [2:0] mode_sel;
        logic osc_sel;
    } fcp_pins_t;
endpackage

// [logic/fcp_cfg_mem.sv]
// Purpose: configuration memory, one write port, registered read port
// Assumes: single clock
// Notes: contents are not reset; the loader clears them word by word
module fcp_cfg_mem #(
    parameter int DW = 8,
    parameter int DEPTH = 64,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [DEPTH];
    logic [DW-1:0] rdata_r;

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        if (rst) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= mem[raddr];
        end
    end

    assign rdata = rdata_r;
endmodule // fcp_cfg_mem

// [verification/fcp_host_model.sv]
// Purpose: far side of the configuration pins: board, host clock, data bus, rom
// Assumes: every change is paced by the bench clock
// Notes: host clock idles low between frames; a released serial line floats to its pull-up
module fcp_host_model (
    input wire logic clk,
    input wire logic hold_init,
    input wire logic init_n_out,
    input wire logic init_n_oe,
    output logic init_n_in,
    input wire logic gen_clk,
    input wire logic gen_oe,
    output logic cfg_clock_in,
    input wire logic d7_out,
    input wire logic d7_oe,
    input wire logic [7:0] host_data,
    input wire logic rom_mode,
    input wire logic ser_src,
    input wire logic [17:0] rom_address,
    output logic [7:0] cfg_data_in,
    output logic cfg_serial_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 1'h0;
    logic ser_bit = 1'h1;
    logic gen_q = 1'h0;
    logic [7:0] rom_q;
    logic [7:0] bus;
    int idx = 0;
    function automatic logic [7:0] rom_byte(input logic [17:0] a);
        return 8'hC3 ^ {a[6:0], 1'h0};
    endfunction
    // board keeps a test strap high; this block has no scan pins to drive
    assign init_n_in = (hold_init || (init_n_oe && !init_n_out)) ? 1'h0 : 1'h1;
    assign cfg_clock_in = gen_oe ? gen_clk : hclk;
    assign bus = rom_mode ? rom_byte(rom_address) : host_data;
    assign cfg_data_in = {d7_oe ? d7_out : bus[7], bus[6:0]};
    assign rom_q = rom_byte(18'(idx / 8));
    assign cfg_serial_in = ser_src ? rom_q[7 - (idx % 8)] : ser_bit;
    // serial rom moves on after each falling device clock, so the bit is steady at the rise
    always @(posedge clk) begin
        gen_q <= gen_clk;
        if (!ser_src) begin
            idx <= 0;
        end else if (gen_q && !gen_clk) begin
            idx <= idx + 1;
        end
    end
    task automatic pulse(input logic b);
        ser_bit <= b;
        repeat (4) @(posedge clk);
        hclk <= 1'h1;
        repeat (4) @(posedge clk);
        hclk <= 1'h0;
    endtask
    task automatic idle();
        ser_bit <= 1'h1;
    endtask
endmodule // fcp_host_model

// [verification/test_fcp_config_pins.sv]
// Purpose: self-checking bench for the configuration pin block
// Assumes: 10 MHz clk, a four-byte image to keep runs short
// Notes: straps latch once per reset, so every mode gets a fresh reset
module test_fcp_config_pins;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int NB = 4;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [2:0] config_mode_select = 3'h0;
    logic osc_speed_select = 1'h0;
    logic hold_init = 1'h1;
    logic chip_sel_low = 1'h1;
    logic chip_sel_high = 1'h0;
    logic write_strobe_n = 1'h1;
    logic read_strobe_n = 1'h1;
    logic [7:0] host_data = 8'hFF;
    logic scan_select = 1'h0;
    logic rom_mode = 1'h0;
    logic ser_src = 1'h0;
    logic [1:0] cfg_mem_raddr = 2'h0;
    logic init_n_in, init_n_out, init_n_oe, cfg_d7_out, cfg_d7_oe, cfg_clock_in, chain_q;
    logic cfg_clock_out, cfg_clock_oe, cfg_serial_in, chain_serial_out, byte_ready;
    logic cfg_busy_high, cfg_busy_low, cfg_pins_oe, cfg_pullup_en, scan_disable, cfg_done;
    logic [7:0] cfg_data_in, cfg_mem_rdata;
    logic [17:0] rom_address;
    logic [7:0] exp_mem [NB];
    int n_fail = 0;
    int compares = 0;

    always #50 clk = ~clk;

    fcp_config_pins #(.CFG_BYTES(NB)) DUT (.clk, .rst, .config_mode_select, .osc_speed_select,
        .init_n_in, .init_n_out, .init_n_oe, .chip_sel_low, .chip_sel_high, .write_strobe_n,
        .read_strobe_n, .cfg_data_in, .cfg_d7_out, .cfg_d7_oe, .cfg_clock_in, .cfg_clock_out,
        .cfg_clock_oe, .cfg_serial_in, .chain_serial_out, .rom_address, .byte_ready,
        .cfg_busy_high, .cfg_busy_low, .cfg_pins_oe, .cfg_pullup_en, .scan_select,
        .scan_disable, .cfg_done, .cfg_mem_raddr, .cfg_mem_rdata);

    fcp_host_model host (.clk, .hold_init, .init_n_out, .init_n_oe, .init_n_in,
        .gen_clk(cfg_clock_out), .gen_oe(cfg_clock_oe), .cfg_clock_in, .d7_out(cfg_d7_out),
        .d7_oe(cfg_d7_oe), .host_data, .rom_mode, .ser_src, .rom_address, .cfg_data_in,
        .cfg_serial_in);

    task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic wait_sig(input logic sel, input int lim);
        int n;
        n = 0;
        while ((sel ? cfg_done : byte_ready) !== 1'h1 && n < lim) begin
            @(negedge clk);
            n++;
        end
        check("wait_bound", 18'(n < lim), 18'h1);
    endtask

    task automatic start(input logic [2:0] m, input logic o, input logic sc);
        int n;
        @(posedge clk);
        config_mode_select <= m;
        osc_speed_select <= o;
        scan_select <= sc;
        hold_init <= 1'h1;
        rom_mode <= (m == 3'h2);
        ser_src <= (m == 3'h0);
        rst <= 1'h1;
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        n = 0;
        @(negedge clk);
        while (init_n_oe === 1'h1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        check("init_low_span", 18'(n >= 100 + NB && n <= 102 + NB), 18'h1);
        repeat (40) @(negedge clk);
        check("ready_while_held", 18'({byte_ready, cfg_clock_oe}), 18'h0);
        @(posedge clk);
        hold_init <= 1'h0;
        wait_sig(1'h0, 10);
        check("busy_pins", 18'({cfg_busy_high, cfg_busy_low, cfg_pins_oe, cfg_pullup_en}), 18'hB);
    endtask

    task automatic finish_run(input logic sc);
        wait_sig(1'h1, 3000);
        repeat (2) @(negedge clk);
        check("user_pins", 18'({cfg_pins_oe, cfg_pullup_en}), 18'h0);
        check("scan_off", 18'(scan_disable), 18'(!sc));
        for (int i = 0; i < NB; i++) begin
            @(posedge clk);
            cfg_mem_raddr <= 2'(i);
            @(posedge clk);
            @(negedge clk);
            check("mem_byte", 18'(cfg_mem_rdata), 18'(exp_mem[i]));
        end
    endtask

    task automatic host_write(input logic [7:0] d, input logic cl, input logic ch, input logic rd);
        @(posedge clk);
        chip_sel_low <= cl;
        chip_sel_high <= ch;
        host_data <= d;
        write_strobe_n <= 1'h0;
        read_strobe_n <= !rd;
        repeat (4) @(posedge clk);
        write_strobe_n <= 1'h1;
        read_strobe_n <= 1'h1;
        chip_sel_low <= 1'h1;
        chip_sel_high <= 1'h0;
        host_data <= 8'hFF;
        @(negedge clk);
        check("d7_in_write", 18'(cfg_d7_oe), 18'h0);
    endtask

    task automatic host_read(input logic exp, input logic desel);
        @(posedge clk);
        chip_sel_low <= 1'h0;
        chip_sel_high <= 1'h1;
        read_strobe_n <= 1'h0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check("d7_status", 18'({cfg_d7_oe, cfg_d7_out, byte_ready}), 18'({1'h1, exp, exp}));
        @(posedge clk);
        if (desel) begin
            chip_sel_high <= 1'h0;
        end else begin
            read_strobe_n <= 1'h1;
        end
        repeat (3) @(posedge clk);
        @(negedge clk);
        check("d7_release", 18'(cfg_d7_oe), 18'h0);
        @(posedge clk);
        read_strobe_n <= 1'h1;
        chip_sel_low <= 1'h1;
        chip_sel_high <= 1'h0;
    endtask

    task automatic gen_period(input int exp);
        int a;
        int b;
        logic p;
        a = 0;
        b = 0;
        p = cfg_clock_out;
        for (int n = 1; n < 60 && b == 0; n++) begin
            @(negedge clk);
            if (cfg_clock_out === 1'h1 && p === 1'h0) begin
                b = (a != 0) ? n : 0;
                a = (a == 0) ? n : a;
            end
            p = cfg_clock_out;
        end
        check("gen_clk_period", 18'(b - a), 18'(exp));
    endtask

    // the daisy-chain output may only move while the host clock is low
    always @(negedge clk) begin
        chain_q <= chain_serial_out;
        if (!rst && !cfg_clock_oe && chain_serial_out !== chain_q) begin
            check("chain_edge", 18'(cfg_clock_in), 18'h0);
        end
    end

    initial begin
        exp_mem = '{8'h81, 8'h42, 8'h24, 8'h18};
        start(3'h3, 1'h0, 1'h0);
        host_write(exp_mem[0], 1'h0, 1'h1, 1'h0);
        host_read(1'h0, 1'h0);
        wait_sig(1'h0, 40);
        host_read(1'h1, 1'h1);
        for (int k = 0; k < 3; k++) begin
            host_write(8'hEE, k != 1, k == 0, 1'h0);
            check("ready_unselected", 18'(byte_ready), 18'h1);
        end
        host_write(exp_mem[1], 1'h0, 1'h1, 1'h1);
        gen_period(2);
        for (int i = 2; i < NB; i++) begin
            wait_sig(1'h0, 40);
            host_write(exp_mem[i], 1'h0, 1'h1, 1'h0);
        end
        finish_run(1'h0);
        for (int i = 0; i < NB; i++) begin
            // even steps make the last serial bit differ from the one before it in bytes 1 and 3
            exp_mem[i] = 8'hC3 ^ 8'(i * 2);
        end
        // straps moved after the latch must not change the mode
        start(3'h7, 1'h1, 1'h1);
        @(posedge clk);
        config_mode_select <= 3'h2;
        for (int i = 0; i < NB * 8; i++) begin
            host.pulse(exp_mem[i / 8][7 - (i % 8)]);
        end
        host.idle();
        repeat (6) @(negedge clk);
        check("chain_last_bit", 18'(chain_serial_out), 18'(exp_mem[NB - 1][0]));
        finish_run(1'h1);
        for (int m = 0; m < 2; m++) begin
            start((m == 0) ? 3'h1 : 3'h4, 1'h0, 1'h0);
            @(posedge clk);
            chip_sel_low <= 1'h0;
            chip_sel_high <= 1'h1;
            host_data <= 8'h77;
            host.pulse(1'h1);
            write_strobe_n <= 1'h0;
            for (int i = 0; i < NB; i++) begin
                host_data <= exp_mem[i];
                host.pulse(1'h1);
            end
            write_strobe_n <= 1'h1;
            chip_sel_low <= 1'h1;
            chip_sel_high <= 1'h0;
            host_data <= 8'hFF;
            finish_run(1'h0);
        end
        start(3'h2, 1'h1, 1'h0);
        @(posedge clk);
        osc_speed_select <= 1'h0;
        gen_period(16);
        wait_sig(1'h1, 3000);
        check("rom_addr_end", rom_address, 18'(NB));
        finish_run(1'h0);
        start(3'h0, 1'h1, 1'h0);
        finish_run(1'h0);
        print_verdict();
    end

    initial begin
        #(20000 * 100);
        n_fail++;
        print_verdict();
    end
endmodule // test_fcp_config_pins
